// ==== common/clk_ctrl_pkg.sv ====
// Purpose: Constants for the system clock select, multiplier and switchback block
// Assumes: One 200 MHz core clock stands in for the oscillator; clocks are enable pulses
// Notes: Register offsets are our own layout on the plain register port
// Contract
// - System clock source: oscillator, oscillator/256, or oscillator times two or four.
// - Machine cycle is the system clock divided by four.
// - Multiplier is the source only when its enable is one and select is 00.
// - Factor select 0 gives times two, 1 gives times four.
// - Select 11 is slow mode: oscillator/256, machine cycle 1024 oscillator clocks.
// - Slow mode runs machine-cycle functions at oscillator/1024 and the system clock at oscillator/256.
// - New rates apply one machine cycle after the changing write.
// - Every select change passes through 10.
// - A disallowed direct transition is rejected; select keeps its value.
// - Multiplier engage: at 10 with blocking 0, clear enable, factor, enable, ready, 00.
// - Engage steps out of order leave the select unchanged.
// - Ready flag sets once the multiplier is stable, about 65536 oscillator cycles.
// - Multiplier clocks from the machine cycle after the 00 write.
// - Leaving multiplier needs only a write of the select.
// - Switchback only while the switchback enable bit 5 is one.
// - Acknowledged external interrupt in slow mode returns to divide-by-four.
// - No switchback if that interrupt is disabled or higher priority in service.
// - Enabled serial port start bit in slow mode returns to divide-by-four.
// - Loading the transmit buffer in slow mode returns to divide-by-four.
package clk_ctrl_pkg;
  localparam logic [3:0] ADDR_PMR = 4'h0;
  localparam logic [3:0] ADDR_EXTENDED_INTERRUPT_FLAG_REGISTER = 4'h1;
  localparam logic [3:0] ADDR_STATE = 4'h2;
  localparam int SEL_HI_BIT = 7;
  localparam int SEL_LO_BIT = 6;
  localparam int SWB_BIT = 5;
  localparam int MULT_EN_BIT = 4;
  localparam int FACTOR_BIT = 3;
  localparam int READY_BIT = 3;
  localparam int BLOCK_BIT = 2;
  localparam logic [1:0] SEL_MULT = 2'h0;
  localparam logic [1:0] SEL_UNDEF = 2'h1;
  localparam logic [1:0] SEL_DIV4 = 2'h2;
  localparam logic [1:0] SEL_SLOW = 2'h3;
  localparam logic [7:0] PMR_RESET = 8'h80;
  localparam int SLOW_DIV = 256;
  localparam int MC_DIV = 4;
  localparam int LOCK_CYCLES = 65536;
  localparam logic [7:0] SLOW_LAST = 8'hFF;
  localparam logic [1:0] MC_LAST = 2'h3;
  typedef enum logic [4:0] {
    ENG_IDLE = 5'b00001,
    ENG_CLEARED = 5'b00010,
    ENG_FACTOR = 5'b00100,
    ENG_ENABLED = 5'b01000,
    ENG_READY = 5'b10000
  } engage_t;
endpackage

// ==== hw/sys_clock_ctrl.sv ====
// Purpose: System clock source select, machine-cycle enable, multiplier engage, switchback
// Assumes: Oscillator ticks are clock_i; multiplied rates appear as enable ratio in phase
// Notes: All clocks leave as one-cycle enables; no gated clocks are made here
`timescale 1ns/1ps
`default_nettype none
module sys_clock_ctrl #(
  parameter int LOCK_TIME = clk_ctrl_pkg::LOCK_CYCLES
) (
  input wire logic clock_i, // 200 MHz core clock, oscillator stand-in
  input wire logic rstn_i, // Async reset, active low
  input wire logic [3:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after read strobe
  input wire logic ext_int_ack_i, // External interrupt acknowledged by CPU
  input wire logic ext_int_en_i, // That interrupt enabled
  input wire logic higher_prio_busy_i, // Higher priority interrupt in service
  input wire logic serial_rx_pin_i, // Serial receive pin, async
  input wire logic serial_en_i, // Serial receiver enabled
  input wire logic tx_buf_load_i, // Transmit buffer loaded, one-cycle pulse
  output logic sys_clk_en_o, // System clock enable pulse
  output logic mc_en_o, // Machine-cycle enable pulse
  output logic [1:0] clk_sel_o, // Active clock select
  output logic slow_clock_mode_o, // Slow mode active
  output logic mult_active_o // Multiplier is the source
);
  import clk_ctrl_pkg::*;

  localparam logic [16:0] LOCK_LAST = 17'(LOCK_TIME - 1);

  logic [1:0] sel_ff; // Software-visible select
  logic [1:0] act_sel_ff; // Select in use by the dividers
  logic [1:0] pend_sel_ff;
  logic pend_ff;
  logic switchback_enable_ff;
  logic multiplier_enable_ff;
  logic multiply_factor_select_ff;
  logic multiplier_blocking_bit_ff;
  logic multiplier_ready_flag_ff;
  logic [16:0] lock_cnt_ff;
  engage_t eng_ff;
  logic [7:0] slow_cnt_ff;
  logic [1:0] mc_cnt_ff;
  logic [1:0] mul_ph_ff;
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic rx_prev_ff;
  logic [7:0] rdata_ff;
  logic sys_en_ff;
  logic mc_en_ff;
  logic slow_mode_ff; // Registered copy of the slow decode
  logic mult_act_ff; // Registered copy of the multiplier decode

  logic pmr_wr;
  logic extended_interrupt_flag_register_wr;
  logic [1:0] wr_sel;
  logic sel_ok;
  logic switchback;
  logic sys_tick;
  logic mc_tick;
  logic apply_sel;
  logic rx_fall;
  logic swb_int;
  logic swb_rx;
  logic swb_tx;
  logic [7:0] pmr_word;
  logic [7:0] extended_interrupt_flag_register_word;
  logic [7:0] state_word;

  assign pmr_wr = wr_i && (addr_i == ADDR_PMR);
  assign extended_interrupt_flag_register_wr = wr_i && (addr_i == ADDR_EXTENDED_INTERRUPT_FLAG_REGISTER);
  assign wr_sel = {wdata_i[SEL_HI_BIT], wdata_i[SEL_LO_BIT]};

  // Only neighbours of 10 are reachable, and 00 only after the full engage walk
  always_comb begin
    sel_ok = 1'b0;
    if (wr_sel == sel_ff) begin
      sel_ok = 1'b1;
    end else if (wr_sel == SEL_UNDEF) begin
      sel_ok = 1'b0;
    end else if (sel_ff == SEL_DIV4 && wr_sel == SEL_SLOW) begin
      sel_ok = 1'b1;
    end else if (sel_ff == SEL_DIV4 && wr_sel == SEL_MULT) begin
      sel_ok = (eng_ff == ENG_READY) && multiplier_ready_flag_ff;
    end else if (wr_sel == SEL_DIV4) begin
      sel_ok = 1'b1;
    end else begin
      sel_ok = 1'b0;
    end
  end

  // Start bit seen as a falling edge of the synchronised receive line
  assign rx_fall = rx_prev_ff && !rx_sync_ff;
  assign swb_int = ext_int_ack_i && ext_int_en_i && !higher_prio_busy_i;
  assign swb_rx = serial_en_i && rx_fall;
  assign swb_tx = tx_buf_load_i;
  assign switchback = switchback_enable_ff && (sel_ff == SEL_SLOW) &&
    (swb_int || swb_rx || swb_tx);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= serial_rx_pin_i;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_ff <= PMR_RESET[SEL_HI_BIT:SEL_LO_BIT];
      switchback_enable_ff <= PMR_RESET[SWB_BIT];
      multiplier_enable_ff <= PMR_RESET[MULT_EN_BIT];
      multiply_factor_select_ff <= PMR_RESET[FACTOR_BIT];
    end else begin
      if (switchback) begin
        sel_ff <= SEL_DIV4;
      end else if (pmr_wr && sel_ok) begin
        sel_ff <= wr_sel;
      end
      if (pmr_wr) begin
        switchback_enable_ff <= wdata_i[SWB_BIT];
        // Enable and factor are frozen while the software select sel_ff is 00
        if (sel_ff != SEL_MULT) begin
          multiplier_enable_ff <= wdata_i[MULT_EN_BIT];
          multiply_factor_select_ff <= wdata_i[FACTOR_BIT];
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      multiplier_blocking_bit_ff <= 1'b0;
    end else if (extended_interrupt_flag_register_wr) begin
      multiplier_blocking_bit_ff <= wdata_i[BLOCK_BIT];
    end
  end

  // Engage walk; any other change of the multiplier bits drops it back to idle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eng_ff <= ENG_IDLE;
    end else if (sel_ff != SEL_DIV4 || multiplier_blocking_bit_ff) begin
      eng_ff <= ENG_IDLE;
    end else if (pmr_wr) begin
      case (eng_ff)
        ENG_IDLE: begin
          eng_ff <= wdata_i[MULT_EN_BIT] ? ENG_IDLE : ENG_CLEARED;
        end
        ENG_CLEARED: begin
          eng_ff <= wdata_i[MULT_EN_BIT] ? ENG_IDLE : ENG_FACTOR;
        end
        ENG_FACTOR: begin
          if (wdata_i[MULT_EN_BIT] && wdata_i[FACTOR_BIT] == multiply_factor_select_ff) begin
            eng_ff <= ENG_ENABLED;
          end else if (wdata_i[MULT_EN_BIT]) begin
            eng_ff <= ENG_IDLE;
          end
        end
        ENG_ENABLED, ENG_READY: begin
          if (!wdata_i[MULT_EN_BIT] || wdata_i[FACTOR_BIT] != multiply_factor_select_ff) begin
            eng_ff <= ENG_IDLE;
          end else if (multiplier_ready_flag_ff) begin
            eng_ff <= ENG_READY;
          end
        end
        default: begin
          eng_ff <= ENG_IDLE;
        end
      endcase
    end else if (eng_ff == ENG_ENABLED && multiplier_ready_flag_ff) begin
      eng_ff <= ENG_READY;
    end
  end

  // Lock timer models the multiplier settling after its enable rises
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_cnt_ff <= '0;
      multiplier_ready_flag_ff <= 1'b0;
    end else if (!multiplier_enable_ff) begin
      lock_cnt_ff <= '0;
      multiplier_ready_flag_ff <= 1'b0;
    end else if (lock_cnt_ff == LOCK_LAST) begin
      multiplier_ready_flag_ff <= 1'b1;
    end else begin
      lock_cnt_ff <= lock_cnt_ff + 17'h0_0001;
    end
  end

  // Select is applied at a machine-cycle boundary so no partial cycle is produced
  assign apply_sel = pend_ff && mc_tick && (sel_ff == pend_sel_ff);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act_sel_ff <= PMR_RESET[SEL_HI_BIT:SEL_LO_BIT];
      pend_sel_ff <= PMR_RESET[SEL_HI_BIT:SEL_LO_BIT];
      pend_ff <= 1'b0;
      slow_mode_ff <= (PMR_RESET[SEL_HI_BIT:SEL_LO_BIT] == SEL_SLOW);
      mult_act_ff <= (PMR_RESET[SEL_HI_BIT:SEL_LO_BIT] == SEL_MULT);
    end else begin
      if (sel_ff != pend_sel_ff) begin
        pend_sel_ff <= sel_ff;
        pend_ff <= 1'b1;
      end else if (apply_sel) begin
        act_sel_ff <= pend_sel_ff;
        slow_mode_ff <= (pend_sel_ff == SEL_SLOW);
        mult_act_ff <= (pend_sel_ff == SEL_MULT);
        pend_ff <= 1'b0;
      end
    end
  end

  // System clock enable per source
  always_comb begin
    case (act_sel_ff)
      SEL_SLOW: sys_tick = (slow_cnt_ff == SLOW_LAST);
      SEL_MULT: sys_tick = multiplier_enable_ff;
      default: sys_tick = 1'b1;
    endcase
  end

  // Multiplied rates are above clock_i; the machine cycle shortens by the factor
  always_comb begin
    mc_tick = 1'b0;
    if (act_sel_ff == SEL_MULT && multiplier_enable_ff) begin
      mc_tick = multiply_factor_select_ff ? 1'b1 : mul_ph_ff[0];
    end else if (sys_tick) begin
      mc_tick = (mc_cnt_ff == MC_LAST);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slow_cnt_ff <= '0;
      mc_cnt_ff <= '0;
      mul_ph_ff <= '0;
    end else begin
      slow_cnt_ff <= (act_sel_ff == SEL_SLOW) ? slow_cnt_ff + 8'h01 : 8'h00;
      // Phase restarts on a source change, else the first new machine cycle is short
      if (apply_sel) begin
        mc_cnt_ff <= '0;
      end else if (sys_tick) begin
        mc_cnt_ff <= mc_cnt_ff + 2'h1;
      end
      mul_ph_ff <= apply_sel ? 2'h0 : mul_ph_ff + 2'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_en_ff <= 1'b0;
      mc_en_ff <= 1'b0;
    end else begin
      sys_en_ff <= sys_tick;
      mc_en_ff <= mc_tick;
    end
  end

  // PMR and flag read words are built by named bit so their map lives only in the package; the state word is eng_ff as is
  always_comb begin
    pmr_word = '0;
    pmr_word[SEL_HI_BIT] = sel_ff[1];
    pmr_word[SEL_LO_BIT] = sel_ff[0];
    pmr_word[SWB_BIT] = switchback_enable_ff;
    pmr_word[MULT_EN_BIT] = multiplier_enable_ff;
    pmr_word[FACTOR_BIT] = multiply_factor_select_ff;
  end

  always_comb begin
    extended_interrupt_flag_register_word = '0;
    extended_interrupt_flag_register_word[READY_BIT] = multiplier_ready_flag_ff;
    extended_interrupt_flag_register_word[BLOCK_BIT] = multiplier_blocking_bit_ff;
  end

  assign state_word = {3'b000, eng_ff};

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= '0;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_PMR: rdata_ff <= pmr_word;
        ADDR_EXTENDED_INTERRUPT_FLAG_REGISTER: rdata_ff <= extended_interrupt_flag_register_word;
        ADDR_STATE: rdata_ff <= state_word;
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata_o = rdata_ff;
  assign sys_clk_en_o = sys_en_ff;
  assign mc_en_o = mc_en_ff;
  assign clk_sel_o = act_sel_ff;
  assign slow_clock_mode_o = slow_mode_ff;
  assign mult_active_o = mult_act_ff;
endmodule
`default_nettype wire

// ==== bench/sys_clock_ctrl_props.sv ====
// Purpose: Port checks for sys_clock_ctrl
// Assumes: Select and rate outputs are registered
// Notes: Slow-mode gap check is coarse; the bench measures the full period
`timescale 1ns/1ps
`default_nettype none
module sys_clock_ctrl_chk (
  input wire logic clock_i, // Clock
  input wire logic rstn_i, // Reset
  input wire logic [3:0] addr_i, // Address
  input wire logic [7:0] wdata_i, // Data
  input wire logic wr_i, // Write
  input wire logic sys_clk_en_o, // Tick
  input wire logic mc_en_o, // Cycle
  input wire logic [1:0] clk_sel_o, // Select
  input wire logic slow_clock_mode_o, // Slow
  input wire logic mult_active_o // Mult
);
  import clk_ctrl_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  logic pmr_wr;
  assign pmr_wr = wr_i && addr_i == ADDR_PMR && wdata_i[SEL_HI_BIT:SEL_LO_BIT] == SEL_SLOW;
  a_mult_decode: assert property (mult_active_o == (clk_sel_o == SEL_MULT))
    else $error("multiplier flag disagrees with select");
  a_slow_decode: assert property (slow_clock_mode_o == (clk_sel_o == SEL_SLOW))
    else $error("slow flag disagrees with select");
  a_no_undef: assert property (clk_sel_o != SEL_UNDEF)
    else $error("undefined select reached");
  a_via_div4: assert property ($changed(clk_sel_o) |->
    clk_sel_o == SEL_DIV4 || $past(clk_sel_o) == SEL_DIV4)
    else $error("select skipped divide-by-four");
  a_slow_apply: assert property (pmr_wr && clk_sel_o == SEL_DIV4 |-> ##[1:8] slow_clock_mode_o)
    else $error("slow mode late");
  a_refuse_direct: assert property (pmr_wr && clk_sel_o == SEL_MULT |=> !slow_clock_mode_o [*8])
    else $error("direct multiplier to slow accepted");
  a_div4_mc_gap: assert property (mc_en_o && clk_sel_o == SEL_DIV4 ##1 clk_sel_o == SEL_DIV4
    |-> (!mc_en_o) [*3])
    else $error("machine cycle too short");
  a_div4_sys: assert property (clk_sel_o == SEL_DIV4 [*3] |-> sys_clk_en_o)
    else $error("system tick missing");
  a_slow_sys: assert property (slow_clock_mode_o [*3] |-> !(sys_clk_en_o && $past(sys_clk_en_o)))
    else $error("slow tick too fast");
endmodule
bind sys_clock_ctrl sys_clock_ctrl_chk i_chk (.clock_i(clock_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .sys_clk_en_o(sys_clk_en_o),
  .mc_en_o(mc_en_o), .clk_sel_o(clk_sel_o), .slow_clock_mode_o(slow_clock_mode_o),
  .mult_active_o(mult_active_o));
`default_nettype wire

// ==== bench/tb_system_clock_divide_switchback.sv ====
// Purpose: Directed test of sys_clock_ctrl
// Assumes: Lock time shortened to 16 cycles
// Notes: Slow mode keeps 1024-cycle machine cycles, which dominates run time
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_divide_switchback;
  import clk_ctrl_pkg::*;
  logic clock_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0;
  logic ack = 0, int_en = 0, busy = 0, rx = 1, rx_en = 0, txl = 0;
  logic sys_en, mc_en, mult_act, slow;
  logic [1:0] sel;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, d, f;
  logic [7:0] sb_exp [6] = '{8'hA0, 8'hA0, 8'hA0, 8'hE0, 8'hE0, 8'hC0};
  int n_errors = 0, n_compared = 0;
  always #2.5 clock_i = ~clock_i;
  sys_clock_ctrl #(.LOCK_TIME(16)) i_dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_int_ack_i(ack), .ext_int_en_i(int_en), .higher_prio_busy_i(busy),
    .serial_rx_pin_i(rx), .serial_en_i(rx_en), .tx_buf_load_i(txl),
    .sys_clk_en_o(sys_en), .mc_en_o(mc_en), .clk_sel_o(sel),
    .slow_clock_mode_o(slow), .mult_active_o(mult_act));
  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic pulse(input bit use_tx);
    @(posedge clock_i);
    if (use_tx)
      txl <= 1'b1;
    else
      ack <= 1'b1;
    @(posedge clock_i);
    txl <= 1'b0;
    ack <= 1'b0;
  endtask
  task automatic wait_sel(input logic [1:0] s);
    int i;
    for (i = 0; i < 3000 && sel !== s; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk({14'h0, sel}, {14'h0, s});
    chk({14'h0, slow, mult_act}, {14'h0, s == SEL_SLOW, s == SEL_MULT});
    if (sel !== s) summarize();
  endtask
  // Period between two ticks of the chosen enable, in clock cycles
  task automatic gap(input bit s, input int exp);
    int i, n;
    n = 0;
    for (i = 0; i < 5000; i++) begin
      @(posedge clock_i);
      #1;
      if ((s ? sys_en : mc_en) === 1'b1 && n > 0) break;
      if (n > 0 || (s ? sys_en : mc_en) === 1'b1) n++;
    end
    chk(n[15:0], exp[15:0]);
    if (i == 5000) summarize();
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(ADDR_PMR, d);
    chk({8'h0, d}, {8'h0, PMR_RESET});
    gap(0, 4);
    wr(ADDR_PMR, 8'h40);
    rd(ADDR_PMR, d);
    chk({8'h0, d}, 16'h0080);
    wr(ADDR_PMR, 8'h00);
    rd(ADDR_PMR, d);
    chk({8'h0, d}, 16'h0080);
    wr(ADDR_EXTENDED_INTERRUPT_FLAG_REGISTER, 8'h04);
    wr(ADDR_PMR, 8'h80);
    wr(ADDR_PMR, 8'h80);
    wr(ADDR_PMR, 8'h90);
    repeat (20) @(posedge clock_i);
    wr(ADDR_PMR, 8'h10);
    rd(ADDR_PMR, d);
    chk({8'h0, d}, 16'h0090);
    for (int k = 0; k < 2; k++) begin
      f = k[0] ? 8'h08 : 8'h00;
      wr(ADDR_EXTENDED_INTERRUPT_FLAG_REGISTER, 8'h00);
      wr(ADDR_PMR, 8'h80);
      wr(ADDR_PMR, 8'h80 | f);
      wr(ADDR_PMR, 8'h90 | f);
      rd(ADDR_EXTENDED_INTERRUPT_FLAG_REGISTER, d);
      chk({12'h0, d[3], 3'h0}, 16'h0000);
      for (int i = 0; i < 40 && d[3] !== 1'b1; i++) rd(ADDR_EXTENDED_INTERRUPT_FLAG_REGISTER, d);
      chk({15'h0, d[3]}, 16'h0001);
      wr(ADDR_PMR, 8'h10 | f);
      wait_sel(SEL_MULT);
      gap(0, k[0] ? 1 : 2);
      wr(ADDR_PMR, 8'hD0 | f);
      rd(ADDR_PMR, d);
      chk({8'h0, d}, {8'h0, 8'h10 | f});
      wr(ADDR_PMR, 8'h90 | f);
      wait_sel(SEL_DIV4);
      gap(0, 4);
    end
    wr(ADDR_PMR, 8'hC0);
    wait_sel(SEL_SLOW);
    gap(0, 1024);
    gap(1, 256);
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_PMR, k == 5 ? 8'hC0 : 8'hE0);
      wait_sel(SEL_SLOW);
      @(posedge clock_i);
      int_en <= k != 3;
      busy <= k == 4;
      rx_en <= k == 1;
      if (k == 1)
        rx <= 1'b0;
      else if (k == 0 || k == 5)
        pulse(1'b1);
      else
        pulse(1'b0);
      repeat (6) @(posedge clock_i);
      rd(ADDR_PMR, d);
      chk({8'h0, d}, {8'h0, sb_exp[k]});
      wr(ADDR_PMR, 8'h80);
      rx <= 1'b1;
      wait_sel(SEL_DIV4);
    end
    summarize();
  end
endmodule
`default_nettype wire
